// *** core/dascp_defines.svh ***
// constants of the dual converter link: widths, offsets, fields, timing
// assumes the system clock runs at the rate given here
`ifndef DASCP_DEFINES_SVH
`define DASCP_DEFINES_SVH
`define DASCP_CLK_MHZ        200
`define DASCP_NBITS          14
`define DASCP_PAIRS          7
`define DASCP_LATENCY        6
`define DASCP_NREGS          4
`define DASCP_FRAME          16
`define DASCP_RW_BIT         15
`define DASCP_ADDR_BITS      7
`define DASCP_FIRST_DATA_BIT 8
`define DASCP_FMT_BIT        0
`define DASCP_CFG_RESET      8'h00
`define DASCP_NS2CYC_UP(ns)  ((((ns) * `DASCP_CLK_MHZ) + 999) / 1000)
`define DASCP_NS2CYC_DN(ns)  (((ns) * `DASCP_CLK_MHZ) / 1000)
`define DASCP_SPI_WR_NS      40
`define DASCP_SPI_RD_NS      250
`define DASCP_SDO_VALID_NS   125
`define DASCP_ENC_MAX_NS     100
`define DASCP_SPI_WR_HALF    (`DASCP_NS2CYC_UP(`DASCP_SPI_WR_NS) / 2)
`define DASCP_SPI_RD_HALF    (`DASCP_NS2CYC_UP(`DASCP_SPI_RD_NS) / 2)
`define DASCP_SDO_VALID_CYC  `DASCP_NS2CYC_DN(`DASCP_SDO_VALID_NS)
`define DASCP_ENC_HALF       (`DASCP_NS2CYC_DN(`DASCP_ENC_MAX_NS) / 2)
`define DASCP_OFF_CTRL       5'h00
`define DASCP_OFF_STATUS     5'h04
`define DASCP_OFF_IRQ_STAT   5'h08
`define DASCP_OFF_IRQ_MASK   5'h0c
`define DASCP_OFF_SAMPLE     5'h10
`define DASCP_OFF_ENC        5'h14
`define DASCP_IRQ_SPI        0
`define DASCP_IRQ_SMP        1
`define DASCP_IRQ_OVR        2
`endif

// *** core/dascp_pkg.sv ***
// types and bit-lane helpers shared by both ends of the converter link
// assumes dascp_defines.svh is on the include path
package dascp_pkg;
  `include "dascp_defines.svh"

  typedef logic [`DASCP_NBITS-1:0] dascp_word_t;
  typedef logic [`DASCP_PAIRS-1:0] dascp_pair_t;

  typedef enum logic [2:0] {
    DASCP_IDLE = 3'b000,
    DASCP_LEAD = 3'b001,
    DASCP_HI   = 3'b010,
    DASCP_LO   = 3'b011,
    DASCP_TAIL = 3'b100
  } dascp_spi_st_t;

  typedef struct packed {
    logic [`DASCP_LATENCY-1:0][`DASCP_NBITS-1:0] pipe_a;
    logic [`DASCP_LATENCY-1:0][`DASCP_NBITS-1:0] pipe_b;
    logic [`DASCP_LATENCY-1:0]                   pof_a;
    logic [`DASCP_LATENCY-1:0]                   pof_b;
    dascp_word_t                                 word_a;
    dascp_word_t                                 word_b;
    logic                                        of_b_hold;
    logic                                        fwd_clk;
    dascp_pair_t                                 data_a;
    dascp_pair_t                                 data_b;
    logic                                        of;
    logic [4:0]                                  bit_cnt;
    logic [`DASCP_FRAME-2:0]                     shift_in;
    logic [`DASCP_ADDR_BITS-1:0]                 addr;
    logic                                        rd_act;
    logic [7:0]                                  shift_out;
    logic                                        sdo_drive;
    logic                                        sdo_oe_b;
    logic [`DASCP_NREGS-1:0][7:0]                cfg;
  } dascp_dev_st_t;

  typedef struct packed {
    logic                    wait_req;
    logic [31:0]             rdata;
    logic                    irq;
    logic [2:0]              stat;
    logic [2:0]              mask;
    logic                    enc_en;
    logic                    enc;
    logic                    enc_n;
    logic [7:0]              enc_cnt;
    dascp_spi_st_t           st;
    logic                    rw;
    logic [`DASCP_FRAME-1:0] cmd;
    logic [5:0]              half;
    logic [5:0]              cnt;
    logic [3:0]              idx;
    logic                    cs_b;
    logic                    sck;
    logic                    sdi;
    logic [7:0]              rd_data;
    dascp_pair_t             ev_a;
    dascp_pair_t             ev_b;
    logic                    of_a;
    dascp_word_t             smp_a;
    dascp_word_t             smp_b;
    logic                    smp_of_a;
    logic                    smp_of_b;
  } dascp_host_st_t;

  function automatic dascp_pair_t dascp_evens(input dascp_word_t w);
    dascp_pair_t p;
    for (int i = 0; i < `DASCP_PAIRS; i++) begin
      p[i] = w[2*i];
    end
    return p;
  endfunction : dascp_evens

  function automatic dascp_pair_t dascp_odds(input dascp_word_t w);
    dascp_pair_t p;
    for (int i = 0; i < `DASCP_PAIRS; i++) begin
      p[i] = w[2*i+1];
    end
    return p;
  endfunction : dascp_odds

  function automatic dascp_word_t dascp_merge(input dascp_pair_t ev, input dascp_pair_t od);
    dascp_word_t w;
    for (int i = 0; i < `DASCP_PAIRS; i++) begin
      w[2*i]   = ev[i];
      w[2*i+1] = od[i];
    end
    return w;
  endfunction : dascp_merge

  // offset binary in, two's complement out when asked: flip the sign bit
  function automatic dascp_word_t dascp_fmt(input dascp_word_t w, input logic twos);
    return twos ? {~w[`DASCP_NBITS-1], w[`DASCP_NBITS-2:0]} : w;
  endfunction : dascp_fmt
endpackage : dascp_pkg

// *** core/dascp_link_if.sv ***
// pins between the converter and its host
// the open-drain readback line is resolved here with an implied pull-up
interface dascp_link_if;
  logic                  encode_pos;
  logic                  encode_neg;
  logic                  forwarded_output_clock;
  dascp_pkg::dascp_pair_t data_a;
  dascp_pkg::dascp_pair_t data_b;
  logic                  over_range_flag;
  logic                  cs_b;
  logic                  sck;
  logic                  sdi;
  logic                  sdo_drive;
  logic                  sdo_oe_b;
  logic                  sdo_line;

  // released line floats high through the external pull-up
  assign sdo_line = sdo_oe_b ? 1'b1 : sdo_drive;

  modport dev_mp (
    input  encode_pos, encode_neg, cs_b, sck, sdi,
    output forwarded_output_clock, data_a, data_b, over_range_flag, sdo_drive, sdo_oe_b
  );
  modport host_mp (
    output encode_pos, encode_neg, cs_b, sck, sdi,
    input  forwarded_output_clock, data_a, data_b, over_range_flag, sdo_line
  );
endinterface : dascp_link_if

// *** core/dascp_sync.sv ***
// two-stage synchroniser with edge detection on the settled stage
// assumes inputs come from outside the clock domain
module dascp_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out,
  output logic      [W-1:0] rise_out,
  output logic      [W-1:0] fall_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
    logic [W-1:0] prev;
  } dascp_sync_st_t;

  dascp_sync_st_t r;
  dascp_sync_st_t n;

  always_comb begin
    n      = r;
    n.meta = d_in;
    n.stab = r.meta;
    n.prev = r.stab;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // edges only from the settled stage, never the first flop
  assign q_out    = r.stab;
  assign rise_out = r.stab & ~r.prev;
  assign fall_out = ~r.stab & r.prev;
endmodule : dascp_sync

// *** core/dascp_dev.sv ***
// converter end: sample pipeline, ddr output pairs, serial config port
// assumes encode and serial pins are slow enough to be oversampled by clock_in
`include "dascp_defines.svh"
module dascp_dev (
  input  wire logic                   clock_in,
  input  wire logic                   rst_b_in,
  dascp_link_if.dev_mp                link,
  input  wire dascp_pkg::dascp_word_t sample_a_in,
  input  wire dascp_pkg::dascp_word_t sample_b_in,
  input  wire logic                   over_a_in,
  input  wire logic                   over_b_in,
  input  wire logic                   programming_mode_select_in,
  output logic                        twos_complement_out
);
  import dascp_pkg::*;

  localparam int PIN_ENC = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_CSB = 2;
  localparam int PIN_SDI = 3;
  localparam int PIN_PMS = 4;
  localparam int PIN_ENN = 5;
  localparam int NPINS   = 6;

  // kept as a figure for timing review; the path below is a few cycles long
  localparam int SDO_VALID_CYC = `DASCP_SDO_VALID_CYC;

  dascp_dev_st_t    r;
  dascp_dev_st_t    n;
  logic [NPINS-1:0] pin_q;
  logic [NPINS-1:0] pin_rise;
  logic [NPINS-1:0] pin_fall;
  logic             serial;
  logic             twos;
  dascp_word_t      out_a;
  dascp_word_t      out_b;
  logic [7:0]       rd_val;
  logic [7:0]       wr_val;
  logic [`DASCP_ADDR_BITS-1:0] wr_addr;

  dascp_sync #(
    .W (NPINS)
  ) u_pin_sync (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .d_in     ({link.encode_neg, programming_mode_select_in, link.sdi, link.cs_b,
                link.sck, link.encode_pos}),
    .q_out    (pin_q),
    .rise_out (pin_rise),
    .fall_out (pin_fall)
  );

  // strap low selects the serial port; high leaves it dormant
  assign serial = ~pin_q[PIN_PMS];
  assign twos   = serial & r.cfg[0][`DASCP_FMT_BIT];
  assign out_a  = dascp_fmt(r.pipe_a[`DASCP_LATENCY-1], twos);
  assign out_b  = dascp_fmt(r.pipe_b[`DASCP_LATENCY-1], twos);

  assign wr_addr = {r.shift_in[`DASCP_ADDR_BITS-2:0], pin_q[PIN_SDI]};
  assign wr_val  = {r.shift_in[6:0], pin_q[PIN_SDI]};
  // unmapped addresses read back as zero
  assign rd_val  = (r.addr < 7'(`DASCP_NREGS)) ? r.cfg[r.addr[1:0]] : 8'h00;

  always_comb begin
    n = r;

    // sample pipeline and output pairs
    // both legs must agree, so a glitch on one leg starts no conversion
    if (pin_rise[PIN_ENC] && pin_fall[PIN_ENN]) begin
      n.pipe_a    = {r.pipe_a[`DASCP_LATENCY-2:0], sample_a_in};
      n.pipe_b    = {r.pipe_b[`DASCP_LATENCY-2:0], sample_b_in};
      n.pof_a     = {r.pof_a[`DASCP_LATENCY-2:0], over_a_in};
      n.pof_b     = {r.pof_b[`DASCP_LATENCY-2:0], over_b_in};
      n.word_a    = out_a;
      n.word_b    = out_b;
      n.fwd_clk   = 1'b0;
      n.data_a    = dascp_evens(out_a);
      n.data_b    = dascp_evens(out_b);
      n.of        = r.pof_a[`DASCP_LATENCY-1];
      n.of_b_hold = r.pof_b[`DASCP_LATENCY-1];
    end else if (pin_fall[PIN_ENC]) begin
      n.fwd_clk = 1'b1;
      n.data_a  = dascp_odds(r.word_a);
      n.data_b  = dascp_odds(r.word_b);
      n.of      = r.of_b_hold;
    end

    // serial configuration port
    n.sdo_drive = 1'b0;
    if (!serial || pin_q[PIN_CSB]) begin
      // a frame cut short by deselect is dropped whole
      n.bit_cnt  = '0;
      n.rd_act   = 1'b0;
      n.sdo_oe_b = 1'b1;
    end else begin
      if (pin_rise[PIN_SCK] && (r.bit_cnt < 5'(`DASCP_FRAME))) begin
        n.shift_in = {r.shift_in[`DASCP_FRAME-3:0], pin_q[PIN_SDI]};
        n.bit_cnt  = r.bit_cnt + 5'd1;
        if (r.bit_cnt == 5'(`DASCP_ADDR_BITS)) begin
          n.rd_act = r.shift_in[`DASCP_ADDR_BITS-1];
          n.addr   = wr_addr;
        end
        // writes never depend on the readback line
        if ((r.bit_cnt == 5'(`DASCP_FRAME - 1)) && !r.rd_act &&
            (r.addr < 7'(`DASCP_NREGS))) begin
          n.cfg[r.addr[1:0]] = wr_val;
        end
      end
      if (pin_fall[PIN_SCK] && r.rd_act) begin
        if (r.bit_cnt == 5'(`DASCP_FIRST_DATA_BIT)) begin
          n.sdo_oe_b  = rd_val[7];
          n.shift_out = {rd_val[6:0], 1'b1};
        end else if (r.bit_cnt < 5'(`DASCP_FRAME)) begin
          n.sdo_oe_b  = r.shift_out[7];
          n.shift_out = {r.shift_out[6:0], 1'b1};
        end else begin
          n.sdo_oe_b = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      r          <= '0;
      r.sdo_oe_b <= 1'b1;
      for (int i = 0; i < `DASCP_NREGS; i++) begin
        r.cfg[i] <= `DASCP_CFG_RESET;
      end
    end else begin
      r <= n;
    end
  end

  assign link.forwarded_output_clock = r.fwd_clk;
  assign link.data_a                 = r.data_a;
  assign link.data_b                 = r.data_b;
  assign link.over_range_flag        = r.of;
  assign link.sdo_drive              = r.sdo_drive;
  assign link.sdo_oe_b               = r.sdo_oe_b;
  assign twos_complement_out         = r.cfg[0][`DASCP_FMT_BIT];
endmodule : dascp_dev

// *** core/dascp_host.sv ***
// host end: encode clock source, sample receiver, serial config master
// assumes an avalon-mm master with waitrequest and a level interrupt sink
`include "dascp_defines.svh"
module dascp_host (
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  dascp_link_if.host_mp    link,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq_out
);
  import dascp_pkg::*;

  localparam int RX_W = 2 * `DASCP_PAIRS + 3;
  localparam int RX_SDO = RX_W - 1;
  localparam int RX_OF  = RX_W - 2;
  localparam logic [7:0] ENC_LAST = 8'(`DASCP_ENC_HALF - 1);

  dascp_host_st_t  r;
  dascp_host_st_t  n;
  logic [RX_W-1:0] rx_q;
  logic [RX_W-1:0] rx_rise;
  logic [RX_W-1:0] rx_fall;
  dascp_pair_t     rx_a;
  dascp_pair_t     rx_b;
  logic [2:0]      ev;
  logic            clr;
  logic            busy;

  dascp_sync #(
    .W (RX_W)
  ) u_rx_sync (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .d_in     ({link.sdo_line, link.over_range_flag, link.data_b, link.data_a,
                link.forwarded_output_clock}),
    .q_out    (rx_q),
    .rise_out (rx_rise),
    .fall_out (rx_fall)
  );

  assign rx_a = rx_q[`DASCP_PAIRS:1];
  assign rx_b = rx_q[2*`DASCP_PAIRS:`DASCP_PAIRS+1];
  assign busy = (r.st != DASCP_IDLE);

  always_comb begin
    n   = r;
    ev  = '0;
    clr = 1'b0;

    // encode source, slowest legal rate, phases far above their minimum
    if (r.enc_en) begin
      if (r.enc_cnt == ENC_LAST) begin
        n.enc_cnt = '0;
        n.enc     = ~r.enc;
        n.enc_n   = r.enc;
      end else begin
        n.enc_cnt = r.enc_cnt + 8'd1;
      end
    end else begin
      n.enc_cnt = '0;
      n.enc     = 1'b0;
      n.enc_n   = 1'b1;
    end

    // ddr receive: even half on clock fall, odd half completes the word
    if (rx_fall[0]) begin
      n.ev_a = rx_a;
      n.ev_b = rx_b;
      n.of_a = rx_q[RX_OF];
    end
    if (rx_rise[0]) begin
      n.smp_a    = dascp_merge(r.ev_a, rx_a);
      n.smp_b    = dascp_merge(r.ev_b, rx_b);
      n.smp_of_a = r.of_a;
      n.smp_of_b = rx_q[RX_OF];
      ev[`DASCP_IRQ_SMP] = 1'b1;
      ev[`DASCP_IRQ_OVR] = r.of_a | rx_q[RX_OF];
    end

    // serial master
    unique case (r.st)
      DASCP_IDLE: begin
      end
      DASCP_LEAD, DASCP_LO: begin
        if (r.cnt == r.half - 6'd1) begin
          n.cnt = '0;
          n.sck = 1'b1;
          n.st  = DASCP_HI;
        end else begin
          n.cnt = r.cnt + 6'd1;
        end
      end
      DASCP_HI: begin
        if (r.cnt == r.half - 6'd1) begin
          n.cnt = '0;
          n.sck = 1'b0;
          if (r.rw && (r.idx >= 4'(`DASCP_FIRST_DATA_BIT))) begin
            n.rd_data = {r.rd_data[6:0], rx_q[RX_SDO]};
          end
          if (r.idx == 4'(`DASCP_FRAME - 1)) begin
            n.st = DASCP_TAIL;
          end else begin
            n.idx = r.idx + 4'd1;
            n.cmd = {r.cmd[`DASCP_FRAME-2:0], 1'b0};
            n.sdi = r.cmd[`DASCP_FRAME-2];
            n.st  = DASCP_LO;
          end
        end else begin
          n.cnt = r.cnt + 6'd1;
        end
      end
      DASCP_TAIL: begin
        if (r.cnt == r.half - 6'd1) begin
          n.cnt  = '0;
          n.cs_b = 1'b1;
          n.st   = DASCP_IDLE;
          ev[`DASCP_IRQ_SPI] = 1'b1;
        end else begin
          n.cnt = r.cnt + 6'd1;
        end
      end
      default: begin
        n.st   = DASCP_IDLE;
        n.cs_b = 1'b1;
        n.sck  = 1'b0;
      end
    endcase

    // avalon slave: one wait cycle, answer on the second
    n.wait_req = 1'b1;
    if ((avs_read || avs_write) && r.wait_req) begin
      n.wait_req = 1'b0;
      unique case (avs_address)
        `DASCP_OFF_CTRL:     n.rdata = {16'h0000, r.cmd};
        `DASCP_OFF_STATUS:   n.rdata = {15'h0000, r.enc_en, r.rd_data, 7'h00, busy};
        `DASCP_OFF_IRQ_STAT: n.rdata = {29'h0, r.stat | ev};
        `DASCP_OFF_IRQ_MASK: n.rdata = {29'h0, r.mask};
        `DASCP_OFF_SAMPLE:   n.rdata = {r.smp_of_b, 1'b0, r.smp_b, r.smp_of_a, 1'b0, r.smp_a};
        `DASCP_OFF_ENC:      n.rdata = {31'h0, r.enc_en};
        default:             n.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && !r.wait_req) begin
      // a command while a frame runs is dropped
      if ((avs_address == `DASCP_OFF_CTRL) && !busy) begin
        n.cmd     = avs_writedata[`DASCP_FRAME-1:0];
        n.rw      = avs_writedata[`DASCP_RW_BIT];
        n.half    = avs_writedata[`DASCP_RW_BIT] ? 6'(`DASCP_SPI_RD_HALF)
                                                 : 6'(`DASCP_SPI_WR_HALF);
        n.sdi     = avs_writedata[`DASCP_RW_BIT];
        n.cs_b    = 1'b0;
        n.cnt     = '0;
        n.idx     = '0;
        n.rd_data = '0;
        n.st      = DASCP_LEAD;
      end
      if (avs_address == `DASCP_OFF_IRQ_MASK) begin
        n.mask = avs_writedata[2:0];
      end
      if (avs_address == `DASCP_OFF_ENC) begin
        n.enc_en = avs_writedata[0];
      end
    end
    if (avs_read && !r.wait_req && (avs_address == `DASCP_OFF_IRQ_STAT)) begin
      clr = 1'b1;
    end
    // a fresh event beats the read-clear
    n.stat = (clr ? 3'b000 : r.stat) | ev;
    n.irq  = |(n.stat & n.mask);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      r          <= '0;
      r.wait_req <= 1'b1;
      r.cs_b     <= 1'b1;
      r.enc_n    <= 1'b1;
      r.st       <= DASCP_IDLE;
    end else begin
      r <= n;
    end
  end

  assign link.encode_pos = r.enc;
  assign link.encode_neg = r.enc_n;
  assign link.cs_b       = r.cs_b;
  assign link.sck        = r.sck;
  assign link.sdi        = r.sdi;
  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.wait_req;
  assign irq_out         = r.irq;
endmodule : dascp_host

// *** bench/dascp_chk.sv ***
// checker: timing relations on the link between converter and host
// assumes link signals, clock and reset are wired in by name from tb
module dascp_chk (
  input wire logic                   clock_in,
  input wire logic                   rst_b_in,
  input wire logic                   encode_pos,
  input wire logic                   encode_neg,
  input wire logic                   forwarded_output_clock,
  input wire dascp_pkg::dascp_pair_t data_a,
  input wire logic                   over_range_flag,
  input wire logic                   cs_b,
  input wire logic                   sck,
  input wire logic                   sdo_drive,
  input wire logic                   sdo_oe_b
);
  timeunit 1ns;
  timeprecision 1ps;
  import dascp_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  logic       sck_r;
  logic [5:0] since_fall_r;
  // saturates so a long idle never wraps into a false pass
  always_ff @(posedge clock_in) begin
    sck_r <= sck;
    if (!rst_b_in || (sck_r && !sck)) begin
      since_fall_r <= 6'h00;
    end else if (since_fall_r != 6'h3f) begin
      since_fall_r <= since_fall_r + 6'h01;
    end
  end
  sdo_low_only_a: assert property (!sdo_oe_b |-> sdo_drive == 1'b0)
    else $error("readback line driven high");
  idle_release_a: assert property (cs_b |-> sdo_oe_b)
    else $error("readback line held while deselected");
  sdo_valid_a: assert property ($changed(sdo_oe_b) |-> since_fall_r < 6'h19)
    else $error("readback bit late after clock fall");
  sck_select_a: assert property ($changed(sck) |-> !cs_b)
    else $error("serial clock moved while deselected");
  sck_half_a: assert property ($changed(sck) |=> $stable(sck)[*3])
    else $error("serial clock half period short");
  enc_comp_a: assert property (encode_neg != encode_pos)
    else $error("encode pair not complementary");
  fwd_low_a: assert property ($rose(encode_pos) |-> ##[1:6] !forwarded_output_clock)
    else $error("no low output phase after encode rise");
  fwd_high_a: assert property ($fell(encode_pos) |-> ##[1:6] forwarded_output_clock)
    else $error("no high output phase after encode fall");
  fwd_cause_a: assert property ($rose(forwarded_output_clock) |-> !encode_pos)
    else $error("output clock rose without encode fall");
  ddr_align_a: assert property ($changed(data_a) |-> $changed(forwarded_output_clock))
    else $error("data moved off an output clock edge");
  of_align_a: assert property ($changed(over_range_flag) |-> $changed(forwarded_output_clock))
    else $error("flag moved off an output clock edge");
endmodule : dascp_chk

// *** bench/tb.sv ***
// bench: converter and host joined by the link, driven over avalon-mm
// assumes core files compiled first; encode runs from the host divider
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dascp_pkg::*;
  logic        clock_in, rst_b_in, ova, ovb, mode_sel, twos;
  logic        rd, wr, wrq, irq;
  dascp_word_t sa, sb;
  logic [4:0]  adr;
  logic [31:0] wdat, rdat, q;
  int          fail_count, check_count;
  dascp_link_if link ();
  dascp_dev u_dascp_dev (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link),
    .sample_a_in(sa), .sample_b_in(sb), .over_a_in(ova), .over_b_in(ovb),
    .programming_mode_select_in(mode_sel), .twos_complement_out(twos));
  dascp_host u_dascp_host (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_readdata(rdat), .avs_waitrequest(wrq), .irq_out(irq));
  dascp_chk u_dascp_chk (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .encode_pos(link.encode_pos), .encode_neg(link.encode_neg),
    .forwarded_output_clock(link.forwarded_output_clock), .data_a(link.data_a),
    .over_range_flag(link.over_range_flag), .cs_b(link.cs_b), .sck(link.sck),
    .sdo_drive(link.sdo_drive), .sdo_oe_b(link.sdo_oe_b));
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  // one bus access; read data lands in q
  task automatic avm(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clock_in);
      n++;
    end while (wrq !== 1'b0 && n < 40);
    q = rdat;
    cmp("waitrequest", 32'h0, wrq);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock_in);
  endtask : avm
  // frame of 16 bits, then poll busy; status ends in q
  task automatic frame(input logic [15:0] c);
    int n;
    n = 0;
    avm(1'b1, 5'h00, {16'h0000, c});
    do begin
      avm(1'b0, 5'h04, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 800);
    cmp("frame_busy", 32'h0, q[0]);
  endtask : frame
  task automatic enc_wait(input int n);
    repeat (n) @(posedge link.encode_pos);
    @(posedge clock_in);
  endtask : enc_wait
  function automatic logic [6:0] pick(input logic [13:0] w, input int o);
    for (int i = 0; i < 7; i++) pick[i] = w[2*i+o];
  endfunction : pick
  task automatic t_reset;
    cmp("twos", 32'h0, twos);
    cmp("sdo", 32'h1, link.sdo_line);
    avm(1'b1, 5'h18, 32'hffff_ffff);
    avm(1'b0, 5'h18, 32'h0);
    cmp("unmapped", 32'h0, q);
    avm(1'b1, 5'h14, 32'h1);
    enc_wait(7);
    avm(1'b0, 5'h10, 32'h0);
    cmp("early_word", 32'h0, q);
    avm(1'b0, 5'h14, 32'h0);
    cmp("enc_run", 32'h1, q);
  endtask : t_reset
  task automatic t_cfg;
    avm(1'b1, 5'h0c, 32'h1);
    frame(16'h0001);
    cmp("twos", 32'h1, twos);
    cmp("irq", 32'h1, irq);
    avm(1'b0, 5'h08, 32'h0);
    cmp("done", 32'h1, q[0]);
    @(negedge clock_in);
    cmp("irq_clr", 32'h0, irq);
    @(posedge clock_in);
    frame(16'h02a5);
    frame(16'h8200);
    cmp("readback", 32'ha5, q[15:8]);
    avm(1'b0, 5'h0c, 32'h0);
    cmp("mask", 32'h1, q);
    frame(16'hff00);
    cmp("rb_unmapped", 32'h0, q[15:8]);
  endtask : t_cfg
  task automatic t_samples;
    logic [13:0] fa, fb;
    fa = sa ^ 14'h2000;
    fb = sb ^ 14'h2000;
    enc_wait(8);
    avm(1'b0, 5'h10, 32'h0);
    cmp("sample", {ovb, 1'b0, fb, ova, 1'b0, fa}, q);
    avm(1'b0, 5'h08, 32'h0);
    cmp("events", 32'h3, q[2:1]);
    @(posedge link.forwarded_output_clock);
    @(posedge clock_in);
    cmp("odd_bits", pick(fa, 1), link.data_a);
    cmp("of_b", ovb, link.over_range_flag);
    @(negedge link.forwarded_output_clock);
    @(posedge clock_in);
    cmp("even_bits", pick(fb, 0), link.data_b);
    cmp("of_a", ova, link.over_range_flag);
    mode_sel <= 1'b1;
    enc_wait(8);
    avm(1'b0, 5'h10, 32'h0);
    cmp("raw_sample", {ovb, 1'b0, sb, ova, 1'b0, sa}, q);
    frame(16'h8200);
    cmp("released", 32'hff, q[15:8]);
  endtask : t_samples
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    rst_b_in = 1'b0;
    sa = 14'h2345;
    sb = 14'h1abc;
    ova = 1'b1;
    ovb = 1'b0;
    mode_sel = 1'b0;
    adr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0;
    fail_count = 0;
    check_count = 0;
    repeat (5) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_cfg();
    t_samples();
    tally_and_finish();
  end
endmodule : tb
